// [hw/rms_stats_bank.sv]
// Ethernet statistics counter bank in the device's memory window.
// Assumes MAC event strobes are on clk and the offset is relative to the window base.
`timescale 1ns/1ns
`default_nettype none

module rms_stats_bank
  import rms_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   ce,
  input  wire logic                   mem_sel,
  input  wire logic                   io_sel,
  input  wire logic                   acc_wr,
  input  wire logic                   acc_rd,
  input  wire logic [3:0]             acc_be,
  input  wire logic [11:0]            acc_off,
  input  wire logic [31:0]            acc_wdata,
  output logic      [31:0]            acc_rdata,
  output logic                        acc_ack,
  input  wire logic                   stats_global_enable,
  input  wire logic [RMS_NUM_CTR-1:0] counter_mask_reg,
  input  wire logic                   rx_done,
  input  wire logic [15:0]            rx_len,
  input  wire logic                   rx_fcs_err,
  input  wire logic                   rx_align_err,
  input  wire logic                   tx_done,
  input  wire logic [15:0]            tx_len,
  input  wire logic                   collision_evt,
  output logic                        stats_threshold_flag
);

  localparam int IX_COL = rms_ix(RMS_OFF_COLLISION);
  localparam int IX_FCS = rms_ix(RMS_OFF_FCS_ALIGN);
  localparam int IX_SHT = rms_ix(RMS_OFF_RX_SHORT);
  localparam int IX_LNG = rms_ix(RMS_OFF_RX_LONG);
  localparam int IX_T64 = rms_ix(RMS_OFF_TX_LEN_64);

  // Counters that may raise the threshold flag
  localparam logic [RMS_NUM_CTR-1:0] THR_SEL =
    (RMS_NUM_CTR'(1) << IX_COL) | (RMS_NUM_CTR'(1) << IX_FCS) |
    (RMS_NUM_CTR'(1) << IX_SHT) | (RMS_NUM_CTR'(1) << IX_LNG);

  logic                   acc_take;
  logic                   in_range;
  logic [4:0]             acc_ix;
  logic                   wr_take;
  logic                   rd_take;
  logic                   rx_bad;
  logic                   rx_short;
  logic                   rx_long;
  logic [2:0]             rx_bin;
  logic [2:0]             tx_bin;
  logic [RMS_NUM_CTR-1:0] ev;
  logic [RMS_NUM_CTR-1:0] inc;
  logic [RMS_NUM_CTR-1:0] wr_sel;
  logic [RMS_NUM_CTR-1:0] hit;
  logic [15:0]            amt [RMS_NUM_CTR];
  logic [31:0]            cnt [RMS_NUM_CTR];

  logic [31:0]            acc_rdata_ff;
  logic [31:0]            nxt_acc_rdata;
  logic                   acc_ack_ff;
  logic                   nxt_acc_ack;
  logic                   flag_ff;
  logic                   nxt_flag;

  // ----------------------------------------------------------------
  // Host access decode
  // ----------------------------------------------------------------
  // I/O cycles never reach the bank, even if the offset matches
  assign acc_take = mem_sel && !io_sel && (acc_be == RMS_BE_DWORD) &&
                    (acc_off[1:0] == 2'b00) && (acc_wr || acc_rd);
  assign in_range = (acc_off >= RMS_OFF_FIRST) && (acc_off <= RMS_OFF_LAST);
  assign acc_ix   = 5'((acc_off - RMS_OFF_FIRST) >> 2);
  assign wr_take  = acc_take && acc_wr && in_range;
  assign rd_take  = acc_take && acc_rd && !acc_wr;

  always_comb
  begin
    wr_sel = '0;
    if (wr_take)
      wr_sel[acc_ix] = 1'b1;
  end

  // ----------------------------------------------------------------
  // Frame classification
  // ----------------------------------------------------------------
  // FCS and alignment errors are both bad FCS, integral octets or not
  assign rx_bad   = rx_fcs_err || rx_align_err;
  assign rx_short = rx_len < RMS_LEN_MIN;
  assign rx_long  = rx_len > RMS_LEN_MAX;
  assign rx_bin   = rms_bin(rx_len);
  assign tx_bin   = rms_bin(tx_len);

  // ----------------------------------------------------------------
  // Counting events
  // ----------------------------------------------------------------
  // Drop, oversize and cast counts have no slot here; the MAC's own
  // lost-frame, too-long and cast-ok registers provide them.
  always_comb
  begin
    ev = '0;
    for (int i = 0; i < RMS_NUM_CTR; i++)
      amt[i] = 16'h0001;
    ev[rms_ix(RMS_OFF_COLLISION)]   = collision_evt;
    ev[rms_ix(RMS_OFF_TX_OCTET)]    = tx_done;
    amt[rms_ix(RMS_OFF_TX_OCTET)]   = tx_len;
    ev[rms_ix(RMS_OFF_TX_FRAME)]    = tx_done;
    ev[rms_ix(RMS_OFF_TX_LEN_64)]   = tx_done && (tx_bin == RMS_BIN_64);
    ev[rms_ix(RMS_OFF_TX_LEN_65)]   = tx_done && (tx_bin == RMS_BIN_65);
    ev[rms_ix(RMS_OFF_TX_LEN_128)]  = tx_done && (tx_bin == RMS_BIN_128);
    ev[rms_ix(RMS_OFF_TX_LEN_256)]  = tx_done && (tx_bin == RMS_BIN_256);
    ev[rms_ix(RMS_OFF_TX_LEN_512)]  = tx_done && (tx_bin == RMS_BIN_512);
    ev[rms_ix(RMS_OFF_TX_LEN_1024)] = tx_done && (tx_bin == RMS_BIN_1024);
    ev[rms_ix(RMS_OFF_FCS_ALIGN)]   = rx_done && rx_bad && !rx_short && !rx_long;
    ev[rms_ix(RMS_OFF_RX_UNDER)]    = rx_done && !rx_bad && rx_short;
    ev[rms_ix(RMS_OFF_RX_SHORT)]    = rx_done && rx_bad && rx_short;
    ev[rms_ix(RMS_OFF_RX_LONG)]     = rx_done && rx_bad && rx_long;
    ev[rms_ix(RMS_OFF_RX_OCTET)]    = rx_done;
    amt[rms_ix(RMS_OFF_RX_OCTET)]   = rx_len;
    ev[rms_ix(RMS_OFF_RX_FRAME)]    = rx_done;
    ev[rms_ix(RMS_OFF_RX_LEN_64)]   = rx_done && (rx_bin == RMS_BIN_64);
    ev[rms_ix(RMS_OFF_RX_LEN_65)]   = rx_done && (rx_bin == RMS_BIN_65);
    ev[rms_ix(RMS_OFF_RX_LEN_128)]  = rx_done && (rx_bin == RMS_BIN_128);
    ev[rms_ix(RMS_OFF_RX_LEN_256)]  = rx_done && (rx_bin == RMS_BIN_256);
    ev[rms_ix(RMS_OFF_RX_LEN_512)]  = rx_done && (rx_bin == RMS_BIN_512);
    ev[rms_ix(RMS_OFF_RX_LEN_1024)] = rx_done && (rx_bin == RMS_BIN_1024);
  end

  // Masked or globally disabled counters hold but stay writable
  assign inc = ev & ~counter_mask_reg & {RMS_NUM_CTR{stats_global_enable}};

  // ----------------------------------------------------------------
  // Counter array
  // ----------------------------------------------------------------
  for (genvar g = 0; g < RMS_NUM_CTR; g++)
  begin : g_ctr
    rms_counter u_ctr (
      .clk     (clk),
      .reset   (reset),
      .ce      (ce),
      .wr_en   (wr_sel[g]),
      .wr_data (acc_wdata),
      .inc_en  (inc[g]),
      .inc_amt (amt[g]),
      .count   (cnt[g]),
      .hit     (hit[g])
    );
  end

  // ----------------------------------------------------------------
  // Read port and threshold flag
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_acc_ack   = acc_take;
    nxt_acc_rdata = RMS_CTR_RESET;
    if (rd_take && in_range)
      nxt_acc_rdata = cnt[acc_ix];
    // A crossing that no later increment can repeat until wrap or rewrite
    nxt_flag = |(hit & THR_SEL);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      acc_rdata_ff <= RMS_CTR_RESET;
      acc_ack_ff   <= 1'b0;
      flag_ff      <= 1'b0;
    end
    else if (ce)
    begin
      acc_rdata_ff <= nxt_acc_rdata;
      acc_ack_ff   <= nxt_acc_ack;
      flag_ff      <= nxt_flag;
    end
  end

  assign acc_rdata            = acc_rdata_ff;
  assign acc_ack              = acc_ack_ff;
  assign stats_threshold_flag = flag_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_io_ignored: assert property (
    @(posedge clk) disable iff (reset)
    (ce && io_sel && acc_rd) |=> !acc_ack_ff)
    else $error("I/O cycle acknowledged by statistics bank");

  a_unmapped_zero: assert property (
    @(posedge clk) disable iff (reset)
    (ce && rd_take && !in_range) |=> (acc_ack_ff && acc_rdata_ff == 32'h0000_0000))
    else $error("Unmapped read did not return zero");

  a_read_collision: assert property (
    @(posedge clk) disable iff (reset)
    (ce && rd_take && acc_off == RMS_OFF_COLLISION) |=> acc_rdata_ff == $past(cnt[IX_COL]))
    else $error("Collision read returned wrong value");

  a_collision_inc: assert property (
    @(posedge clk) disable iff (reset)
    (ce && collision_evt && stats_global_enable && !counter_mask_reg[IX_COL] &&
     !wr_sel[IX_COL]) |=> cnt[IX_COL] == $past(cnt[IX_COL]) + 32'h0000_0001)
    else $error("Collision not counted");

  a_fcs_window: assert property (
    @(posedge clk) disable iff (reset)
    (ce && rx_done && rx_bad && rx_len >= 16'h0040 && rx_len <= 16'h05EE &&
     stats_global_enable && !counter_mask_reg[IX_FCS] && !wr_sel[IX_FCS])
    |=> cnt[IX_FCS] == $past(cnt[IX_FCS]) + 32'h0000_0001)
    else $error("Bad in-range frame not counted");

  a_mask_holds: assert property (
    @(posedge clk) disable iff (reset)
    (ce && (!stats_global_enable || counter_mask_reg[IX_COL]) && !wr_sel[IX_COL])
    |=> $stable(cnt[IX_COL]))
    else $error("Disabled counter changed");

  a_flag_raise: assert property (
    @(posedge clk) disable iff (reset)
    (ce && cnt[IX_COL] == 32'h0000_BFFF && inc[IX_COL] && !wr_sel[IX_COL])
    |=> stats_threshold_flag)
    else $error("Threshold reached without flag");

  a_flag_cause: assert property (
    @(posedge clk) disable iff (reset)
    (ce && !(|(hit & THR_SEL))) |=> !stats_threshold_flag)
    else $error("Flag raised without a threshold step");

  a_short_bad: assert property (
    @(posedge clk) disable iff (reset)
    (ce && rx_done && rx_bad && rx_len < 16'h0040 && stats_global_enable &&
     !counter_mask_reg[IX_SHT] && !wr_sel[IX_SHT])
    |=> cnt[IX_SHT] == $past(cnt[IX_SHT]) + 32'h0000_0001)
    else $error("Short bad frame not counted");

  a_long_bad: assert property (
    @(posedge clk) disable iff (reset)
    (ce && rx_done && rx_bad && rx_len > 16'h05EE && stats_global_enable &&
     !counter_mask_reg[IX_LNG] && !wr_sel[IX_LNG])
    |=> cnt[IX_LNG] == $past(cnt[IX_LNG]) + 32'h0000_0001)
    else $error("Long bad frame not counted");

  a_tx_bin_64: assert property (
    @(posedge clk) disable iff (reset)
    (ce && tx_done && tx_len == 16'h0040 && stats_global_enable &&
     !counter_mask_reg[IX_T64] && !wr_sel[IX_T64])
    |=> cnt[IX_T64] == $past(cnt[IX_T64]) + 32'h0000_0001)
    else $error("Transmitted 64-octet frame not counted");

  a_reset_zero: assert property (
    @(posedge clk) disable iff (reset)
    $fell(reset) |-> (cnt[IX_COL] == 32'h0000_0000 && cnt[IX_FCS] == 32'h0000_0000))
    else $error("Counter not zero after reset");

  a_ack_follows: assert property (
    @(posedge clk) disable iff (reset)
    (ce && acc_take) |=> acc_ack_ff)
    else $error("Taken access not acknowledged");

  a_part_refused: assert property (
    @(posedge clk) disable iff (reset)
    (ce && (acc_be != RMS_BE_DWORD || acc_off[1:0] != 2'b00)) |=> !acc_ack_ff)
    else $error("Partial or misaligned access acknowledged");

  a_write_lands: assert property (
    @(posedge clk) disable iff (reset)
    (ce && wr_sel[IX_COL] && !inc[IX_COL]) |=> cnt[IX_COL] == $past(acc_wdata))
    else $error("Host write to collision counter lost");

  // A frozen cycle must not leak a count, an ack or a flag pulse
  a_ce_freeze: assert property (
    @(posedge clk) disable iff (reset)
    (!ce) |=> ($stable(cnt[IX_COL]) && $stable(acc_ack_ff) && $stable(flag_ff)))
    else $error("State changed while clock enable low");

  a_flag_once: assert property (
    @(posedge clk) disable iff (reset)
    (ce && cnt[IX_COL] == 32'h0000_C000 && inc[IX_COL] && !wr_sel[IX_COL] &&
     !inc[IX_FCS] && !inc[IX_SHT] && !inc[IX_LNG]) |=> !stats_threshold_flag)
    else $error("Flag raised again past the threshold");

  a_fcs_flag: assert property (
    @(posedge clk) disable iff (reset)
    (ce && cnt[IX_FCS] == 32'h0000_BFFF && inc[IX_FCS] && !wr_sel[IX_FCS])
    |=> stats_threshold_flag)
    else $error("Error counter threshold reached without flag");

endmodule // rms_stats_bank

`default_nettype wire

// [hw/rms_pkg.sv]
// Package for the Ethernet statistics counter bank: offsets, limits, helpers.
// Assumes the offset seen by the bank is already relative to the memory window base.
`default_nettype none

package rms_pkg;

  // ----------------------------------------------------------------
  // Counter map, one 32-bit word per offset
  // ----------------------------------------------------------------
  localparam logic [11:0] RMS_OFF_COLLISION   = 12'h100;
  localparam logic [11:0] RMS_OFF_TX_OCTET    = 12'h104;
  localparam logic [11:0] RMS_OFF_TX_FRAME    = 12'h108;
  localparam logic [11:0] RMS_OFF_TX_LEN_64   = 12'h10C;
  localparam logic [11:0] RMS_OFF_TX_LEN_65   = 12'h110;
  localparam logic [11:0] RMS_OFF_TX_LEN_128  = 12'h114;
  localparam logic [11:0] RMS_OFF_TX_LEN_256  = 12'h118;
  localparam logic [11:0] RMS_OFF_TX_LEN_512  = 12'h11C;
  localparam logic [11:0] RMS_OFF_TX_LEN_1024 = 12'h120;
  localparam logic [11:0] RMS_OFF_FCS_ALIGN   = 12'h124;
  localparam logic [11:0] RMS_OFF_RX_UNDER    = 12'h128;
  localparam logic [11:0] RMS_OFF_RX_SHORT    = 12'h12C;
  localparam logic [11:0] RMS_OFF_RX_LONG     = 12'h130;
  localparam logic [11:0] RMS_OFF_RX_OCTET    = 12'h134;
  localparam logic [11:0] RMS_OFF_RX_FRAME    = 12'h138;
  localparam logic [11:0] RMS_OFF_RX_LEN_64   = 12'h13C;
  localparam logic [11:0] RMS_OFF_RX_LEN_65   = 12'h140;
  localparam logic [11:0] RMS_OFF_RX_LEN_128  = 12'h144;
  localparam logic [11:0] RMS_OFF_RX_LEN_256  = 12'h148;
  localparam logic [11:0] RMS_OFF_RX_LEN_512  = 12'h14C;
  localparam logic [11:0] RMS_OFF_RX_LEN_1024 = 12'h150;
  localparam logic [11:0] RMS_OFF_FIRST       = RMS_OFF_COLLISION;
  localparam logic [11:0] RMS_OFF_LAST        = RMS_OFF_RX_LEN_1024;
  localparam int          RMS_NUM_CTR         = 21;

  // ----------------------------------------------------------------
  // Values and limits
  // ----------------------------------------------------------------
  localparam logic [31:0] RMS_CTR_RESET = 32'h0000_0000;
  localparam logic [31:0] RMS_THRESHOLD = 32'h0000_C000;
  localparam logic [3:0]  RMS_BE_DWORD  = 4'hF;
  localparam logic [15:0] RMS_LEN_MIN   = 16'h0040;
  localparam logic [15:0] RMS_LEN_127   = 16'h007F;
  localparam logic [15:0] RMS_LEN_255   = 16'h00FF;
  localparam logic [15:0] RMS_LEN_511   = 16'h01FF;
  localparam logic [15:0] RMS_LEN_1023  = 16'h03FF;
  localparam logic [15:0] RMS_LEN_MAX   = 16'h05EE;

  // Length bin codes
  localparam logic [2:0] RMS_BIN_64   = 3'h0;
  localparam logic [2:0] RMS_BIN_65   = 3'h1;
  localparam logic [2:0] RMS_BIN_128  = 3'h2;
  localparam logic [2:0] RMS_BIN_256  = 3'h3;
  localparam logic [2:0] RMS_BIN_512  = 3'h4;
  localparam logic [2:0] RMS_BIN_1024 = 3'h5;
  localparam logic [2:0] RMS_BIN_NONE = 3'h6;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic int rms_ix(input logic [11:0] off);
    return int'((off - RMS_OFF_FIRST) >> 2);
  endfunction

  function automatic logic [2:0] rms_bin(input logic [15:0] len);
    if (len < RMS_LEN_MIN)        return RMS_BIN_NONE;
    else if (len == RMS_LEN_MIN)  return RMS_BIN_64;
    else if (len <= RMS_LEN_127)  return RMS_BIN_65;
    else if (len <= RMS_LEN_255)  return RMS_BIN_128;
    else if (len <= RMS_LEN_511)  return RMS_BIN_256;
    else if (len <= RMS_LEN_1023) return RMS_BIN_512;
    else                          return RMS_BIN_1024;
  endfunction

endpackage

`default_nettype wire

// [hw/rms_counter.sv]
// One 32-bit statistics counter with host write and threshold detect.
// Assumes the increment amount is at most 16 bits and comes from the same clock.
`timescale 1ns/1ns
`default_nettype none

module rms_counter
  import rms_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_data,
  input  wire logic        inc_en,
  input  wire logic [15:0] inc_amt,
  output logic      [31:0] count,
  output logic             hit
);

  logic [31:0] count_ff;
  logic [31:0] nxt_count;
  logic [31:0] add;

  // ----------------------------------------------------------------
  // Next value
  // ----------------------------------------------------------------
  // An event in the write cycle is added to the written value, not lost
  always_comb
  begin
    add       = inc_en ? {16'h0000, inc_amt} : RMS_CTR_RESET;
    nxt_count = (wr_en ? wr_data : count_ff) + add;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      count_ff <= RMS_CTR_RESET;
    else if (ce)
      count_ff <= nxt_count;
  end

  // Only a counting step onto the threshold hits; a host write does not
  assign hit   = inc_en && !wr_en && (count_ff != RMS_THRESHOLD) && (nxt_count == RMS_THRESHOLD);
  assign count = count_ff;

endmodule // rms_counter

`default_nettype wire

// [verif/rms_mac_model.sv]
// Behavioural MAC receive/transmit/collision source for the statistics bank.
// Assumes the bench calls one task at a time; all drives land on the falling edge.
`timescale 1ns/1ns
`default_nettype none

module rms_mac_model
(
  input  wire logic        clk,
  output logic             rx_done,
  output logic      [15:0] rx_len,
  output logic             rx_fcs_err,
  output logic             rx_align_err,
  output logic             tx_done,
  output logic      [15:0] tx_len,
  output logic             collision_evt
);
  // ----------------------------------------------------------------
  // Idle state
  // ----------------------------------------------------------------
  initial
  begin
    rx_done       = 1'b0;
    rx_len        = 16'hFFFF;
    rx_fcs_err    = 1'b1;
    rx_align_err  = 1'b1;
    tx_done       = 1'b0;
    tx_len        = 16'hFFFF;
    collision_evt = 1'b0;
  end

  // ----------------------------------------------------------------
  // Frame and collision strobes
  // ----------------------------------------------------------------
  // Released fields show the inverse so a stale value never reads as live
  task automatic rx_frame(input logic [15:0] len, input logic fcs,
                          input logic align);
    @(negedge clk);
    rx_done      = 1'b1;
    rx_len       = len;
    rx_fcs_err   = fcs;
    rx_align_err = align;
    @(negedge clk);
    rx_done      = 1'b0;
    rx_len       = ~len;
    rx_fcs_err   = ~fcs;
    rx_align_err = ~align;
  endtask

  task automatic tx_frame(input logic [15:0] len);
    @(negedge clk);
    tx_done = 1'b1;
    tx_len  = len;
    @(negedge clk);
    tx_done = 1'b0;
    tx_len  = ~len;
  endtask

  task automatic collide();
    @(negedge clk);
    collision_evt = 1'b1;
    @(negedge clk);
    collision_evt = 1'b0;
  endtask
endmodule // rms_mac_model

`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the statistics counter bank.
// Assumes the MAC model drives the event ports; host accesses are driven here.
`timescale 1ns/1ns
`default_nettype none

module testbench
  import rms_pkg::*;
;
  logic                   clk, reset, ce, mem_sel, io_sel, acc_wr, acc_rd, acc_ack;
  logic [3:0]             acc_be;
  logic [11:0]            acc_off;
  logic [31:0]            acc_wdata, acc_rdata, rd;
  logic                   stats_global_enable, stats_threshold_flag, ack;
  logic [RMS_NUM_CTR-1:0] counter_mask_reg;
  logic                   rx_done, rx_fcs_err, rx_align_err, tx_done, collision_evt;
  logic [15:0]            rx_len, tx_len;
  logic [11:0]            thr_off [4];
  int                     n_mismatch, samples_checked, n_flag, n0;

  // ----------------------------------------------------------------
  // Design, partner and flag monitor
  // ----------------------------------------------------------------
  rms_stats_bank u_dut (.clk(clk), .reset(reset), .ce(ce), .mem_sel(mem_sel),
    .io_sel(io_sel), .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_be(acc_be), .acc_off(acc_off),
    .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_ack(acc_ack),
    .stats_global_enable(stats_global_enable), .counter_mask_reg(counter_mask_reg),
    .rx_done(rx_done), .rx_len(rx_len), .rx_fcs_err(rx_fcs_err),
    .rx_align_err(rx_align_err), .tx_done(tx_done), .tx_len(tx_len),
    .collision_evt(collision_evt), .stats_threshold_flag(stats_threshold_flag));

  rms_mac_model u_mac (.clk(clk), .rx_done(rx_done), .rx_len(rx_len),
    .rx_fcs_err(rx_fcs_err), .rx_align_err(rx_align_err), .tx_done(tx_done),
    .tx_len(tx_len), .collision_evt(collision_evt));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial n_flag = 0;
  // Sampled mid-cycle, where the registered pulse has settled
  always @(negedge clk) if (stats_threshold_flag === 1'b1) n_flag <= n_flag + 1;

  // ----------------------------------------------------------------
  // Host access and compare tasks
  // ----------------------------------------------------------------
  task automatic bus(input logic wr, input logic [11:0] off, input logic [31:0] wd,
                     input logic [3:0] be, input logic io);
    @(negedge clk);
    // Select stays up on I/O cycles so only the io_sel gate can refuse them
    mem_sel   = 1'b1;
    io_sel    = io;
    acc_wr    = wr;
    acc_rd    = ~wr;
    acc_be    = be;
    acc_off   = off;
    acc_wdata = wd;
    @(negedge clk);
    rd        = acc_rdata;
    ack       = acc_ack;
    mem_sel   = 1'b0;
    io_sel    = 1'b0;
    acc_wr    = 1'b0;
    acc_rd    = 1'b0;
    acc_off   = ~off;
    acc_wdata = ~wd;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [11:0] off, input logic [31:0] exp);
    bus(1'b0, off, 32'h0000_0000, RMS_BE_DWORD, 1'b0);
    cmp({31'h0000_0000, ack}, 32'h0000_0001);
    cmp(rd, exp);
  endtask

  task automatic wr(input logic [11:0] off, input logic [31:0] wd, input logic [3:0] be,
                    input logic io, input logic exp_ack);
    bus(1'b1, off, wd, be, io);
    cmp({31'h0000_0000, ack}, {31'h0000_0000, exp_ack});
  endtask

  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    n_mismatch = 0;
    samples_checked = 0;
    reset = 1'b1;
    ce = 1'b1;
    {mem_sel, io_sel, acc_wr, acc_rd} = 4'h0;
    acc_be = 4'h0;
    acc_off = 12'h000;
    acc_wdata = 32'h0000_0000;
    stats_global_enable = 1'b1;
    counter_mask_reg = '0;
    thr_off = '{RMS_OFF_COLLISION, RMS_OFF_FCS_ALIGN, RMS_OFF_RX_SHORT, RMS_OFF_RX_LONG};
    repeat (20) @(negedge clk);
    reset = 1'b0;
    for (int i = 0; i < RMS_NUM_CTR; i++)
      rdchk(RMS_OFF_FIRST + 12'(4 * i), RMS_CTR_RESET);
    rdchk(12'h154, 32'h0000_0000);
    wr(RMS_OFF_COLLISION, 32'hA5A5_0001, RMS_BE_DWORD, 1'b0, 1'b1);
    wr(RMS_OFF_COLLISION, 32'h1111_1111, RMS_BE_DWORD, 1'b1, 1'b0);
    wr(RMS_OFF_COLLISION, 32'h2222_2222, 4'h3, 1'b0, 1'b0);
    wr(RMS_OFF_COLLISION + 12'h002, 32'h3333_3333, RMS_BE_DWORD, 1'b0, 1'b0);
    bus(1'b0, RMS_OFF_COLLISION, 32'h0000_0000, RMS_BE_DWORD, 1'b1);
    cmp({31'h0000_0000, ack}, 32'h0000_0000);
    cmp(rd, 32'h0000_0000);
    rdchk(RMS_OFF_COLLISION, 32'hA5A5_0001);
    wr(RMS_OFF_FCS_ALIGN, 32'h5A5A_0002, RMS_BE_DWORD, 1'b0, 1'b1);
    rdchk(RMS_OFF_FCS_ALIGN, 32'h5A5A_0002);
    wr(RMS_OFF_COLLISION, 32'h0000_0000, RMS_BE_DWORD, 1'b0, 1'b1);
    wr(RMS_OFF_FCS_ALIGN, 32'h0000_0000, RMS_BE_DWORD, 1'b0, 1'b1);
    // Events
    repeat (3) u_mac.collide();
    rdchk(RMS_OFF_COLLISION, 32'h0000_0003);
    u_mac.rx_frame(16'h003F, 1'b1, 1'b0);
    u_mac.rx_frame(16'h0040, 1'b1, 1'b0);
    u_mac.rx_frame(16'h05EE, 1'b0, 1'b1);
    u_mac.rx_frame(16'h05EF, 1'b1, 1'b0);
    u_mac.rx_frame(16'h0040, 1'b0, 1'b0);
    rdchk(RMS_OFF_FCS_ALIGN, 32'h0000_0002);
    rdchk(RMS_OFF_RX_SHORT, 32'h0000_0001);
    rdchk(RMS_OFF_RX_LONG, 32'h0000_0001);
    // Enable and mask gating; a dropped event is lost for good
    counter_mask_reg[9] = 1'b1;
    u_mac.rx_frame(16'h0040, 1'b1, 1'b0);
    rdchk(RMS_OFF_FCS_ALIGN, 32'h0000_0002);
    counter_mask_reg[9] = 1'b0;
    stats_global_enable = 1'b0;
    u_mac.collide();
    rdchk(RMS_OFF_COLLISION, 32'h0000_0003);
    stats_global_enable = 1'b1;
    // Clock enable low freezes the bank; the collision is lost
    ce = 1'b0;
    u_mac.collide();
    ce = 1'b1;
    rdchk(RMS_OFF_COLLISION, 32'h0000_0003);
    // Transmit counters mirror receive definitions
    wr(RMS_OFF_RX_OCTET, 32'h0000_0000, RMS_BE_DWORD, 1'b0, 1'b1);
    wr(RMS_OFF_RX_LEN_65, 32'h0000_0000, RMS_BE_DWORD, 1'b0, 1'b1);
    u_mac.rx_frame(16'h0064, 1'b0, 1'b0);
    u_mac.tx_frame(16'h0064);
    rdchk(RMS_OFF_RX_OCTET, 32'h0000_0064);
    rdchk(RMS_OFF_TX_OCTET, 32'h0000_0064);
    rdchk(RMS_OFF_RX_LEN_65, 32'h0000_0001);
    rdchk(RMS_OFF_TX_LEN_65, 32'h0000_0001);
    rdchk(RMS_OFF_TX_FRAME, 32'h0000_0001);
    // Threshold flag: a host write onto it stays silent
    n0 = n_flag;
    wr(RMS_OFF_COLLISION, RMS_THRESHOLD, RMS_BE_DWORD, 1'b0, 1'b1);
    repeat (3) @(negedge clk);
    cmp(32'(n_flag), 32'(n0));
    for (int k = 0; k < 4; k++)
    begin
      wr(thr_off[k], 32'h0000_BFFF, RMS_BE_DWORD, 1'b0, 1'b1);
      repeat (2)
      begin
        if (k == 0) u_mac.collide();
        else if (k == 1) u_mac.rx_frame(16'h0040, 1'b1, 1'b0);
        else if (k == 2) u_mac.rx_frame(16'h003F, 1'b1, 1'b0);
        else u_mac.rx_frame(16'h05EF, 1'b0, 1'b1);
      end
      repeat (2) @(negedge clk);
      cmp(32'(n_flag), 32'(n0 + k + 1));
      rdchk(thr_off[k], 32'h0000_C001);
    end
    summarize();
  end

  // Whole run needs under two hundred cycles; the margin is generous
  initial
  begin
    #(100 * 20000);
    n_mismatch++;
    summarize();
  end
endmodule // testbench

`default_nettype wire
